// File: include/psi_conv_if.sv
// Signals between the serial front end and the conversion sequencer.
`timescale 1ns/1ps
interface psi_conv_if;
    logic clear;
    logic start;
    logic pressure;
    logic fastDiv;
    logic mclkTick;
    logic busy;
    logic done;
    logic [15:0] result;

    modport ctrl
    (
        output clear,
        output start,
        output pressure,
        output fastDiv,
        output mclkTick,
        input busy,
        input done,
        input result
    );

    modport engine
    (
        input clear,
        input start,
        input pressure,
        input fastDiv,
        input mclkTick,
        output busy,
        output done,
        output result
    );
endinterface : psi_conv_if

// File: include/psi_pkg.sv
// Constants and types shared by the pressure sensor serial slave.
package psi_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h77;
    localparam logic [7:0] REG_RESULT = 8'hf6;
    localparam logic [7:0] REG_CAL_ONE = 8'hf8;
    localparam logic [7:0] REG_CAL_TWO = 8'hfa;
    localparam logic [7:0] REG_CAL_THREE = 8'hfc;
    localparam logic [7:0] REG_CAL_FOUR = 8'hfe;
    localparam logic [7:0] REG_CTRL = 8'hf4;
    localparam logic [7:0] CTRL_TEMP_SLOW = 8'hee;
    localparam logic [7:0] CTRL_TEMP_FAST = 8'hea;
    localparam logic [7:0] CTRL_PRES_SLOW = 8'hf4;
    localparam logic [7:0] CTRL_PRES_FAST = 8'hf0;
    localparam int CTRL_PRESCALE_BIT = 2;
    localparam logic [6:0] DIV_SLOW = 7'h02;
    localparam logic [6:0] DIV_FAST = 7'h40;
    localparam int CONV_TIME_MS = 34;
    localparam int INT_FREQ_SLOW_HZ = 16384;
    localparam int INT_FREQ_FAST_HZ = 15625;
    // Longest time rounds down; slower internal rate bounds both selections
    localparam int CONV_TICKS = (CONV_TIME_MS * INT_FREQ_FAST_HZ) / 1000;
    localparam int CAL_WORDS = 4;
    localparam int WORD_WIDTH = 16;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_WRITE = 2'b10,
        ST_READ = 2'b11
    } psi_state_t;
endpackage : psi_pkg

// File: src/psi_conv.sv
// Conversion sequencer: prescales the master clock and times one conversion.
`timescale 1ns/1ps
module psi_conv
    import psi_pkg::*;
#(
    parameter int CONV_LEN = psi_pkg::CONV_TICKS
)
(
    input wire logic sys_clk,
    input wire logic rst,
    psi_conv_if.engine cv,
    input wire logic [15:0] tempSample,
    input wire logic [15:0] pressSample
);
    import psi_pkg::*;

    // Elaboration refuses lengths the 16-bit tick counter cannot hold
    if (CONV_LEN < 1 || CONV_LEN > 65535)
    begin : gLenCheck
        $error("psi_conv: CONV_LEN out of range");
    end

    logic [6:0] preCnt_q;
    logic [15:0] tickCnt_q;
    logic busy_q;
    logic done_q;
    logic pressure_q;
    logic fastDiv_q;
    logic [15:0] result_q;
    logic intTick;

    // Internal clock tick after 2 or 64 master clock edges
    assign intTick = cv.mclkTick
        && (preCnt_q == ((fastDiv_q ? DIV_FAST : DIV_SLOW) - 7'h01));

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            preCnt_q <= 7'h00;
        else if (cv.clear || !busy_q || cv.start)
            preCnt_q <= 7'h00;
        else if (intTick)
            preCnt_q <= 7'h00;
        else if (cv.mclkTick)
            preCnt_q <= preCnt_q + 7'h01;
    end

    // A stalled master clock simply freezes the conversion
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            busy_q <= 1'b0;
            tickCnt_q <= 16'h0000;
            pressure_q <= 1'b0;
            fastDiv_q <= 1'b0;
        end
        else if (cv.clear)
        begin
            busy_q <= 1'b0;
            tickCnt_q <= 16'h0000;
            pressure_q <= 1'b0;
            fastDiv_q <= 1'b0;
        end
        else if (cv.start)
        begin
            // New command restarts any conversion in progress
            busy_q <= 1'b1;
            tickCnt_q <= 16'h0000;
            pressure_q <= cv.pressure;
            fastDiv_q <= cv.fastDiv;
        end
        else if (busy_q && intTick)
        begin
            if (tickCnt_q == 16'(CONV_LEN - 1))
                busy_q <= 1'b0;
            tickCnt_q <= tickCnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            done_q <= 1'b0;
            result_q <= RESULT_RESET;
        end
        else if (cv.clear)
        begin
            done_q <= 1'b0;
            result_q <= RESULT_RESET;
        end
        else
        begin
            done_q <= busy_q && intTick && !cv.start && (tickCnt_q == 16'(CONV_LEN - 1));
            if (busy_q && intTick && !cv.start && (tickCnt_q == 16'(CONV_LEN - 1)))
                result_q <= pressure_q ? pressSample : tempSample;
        end
    end

    assign cv.busy = busy_q;
    assign cv.done = done_q;
    assign cv.result = result_q;
endmodule : psi_conv

// File: src/psi_top.sv
// Serial slave of the barometric sensor with calibration memory and control.
`timescale 1ns/1ps
module psi_top
    import psi_pkg::*;
#(
    parameter logic [15:0] CAL_WORD_ONE = 16'h1111,
    parameter logic [15:0] CAL_WORD_TWO = 16'h2222,
    parameter logic [15:0] CAL_WORD_THREE = 16'h3333,
    parameter logic [15:0] CAL_WORD_FOUR = 16'h4444,
    parameter int CONV_LEN = psi_pkg::CONV_TICKS
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic master_clear_n,
    input wire logic mclkIn,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [15:0] tempSample,
    input wire logic [15:0] pressSample,
    output logic convBusy
);
    import psi_pkg::*;

    // Elaboration refuses lengths the 16-bit tick counter cannot hold
    if (CONV_LEN < 1 || CONV_LEN > 65535)
    begin : gLenCheck
        $error("psi_top: CONV_LEN out of range");
    end

    // Calibration memory, fixed per unit
    localparam logic [15:0] CAL_ROM [CAL_WORDS] = '{CAL_WORD_ONE, CAL_WORD_TWO,
        CAL_WORD_THREE, CAL_WORD_FOUR};

    psi_conv_if cv();

    psi_state_t state_q;
    logic [2:0] sclSync_q;
    logic [2:0] sdaSync_q;
    logic [2:0] mclkSync_q;
    logic [1:0] clrSync_q;
    logic [3:0] bitCnt_q;
    logic [7:0] rxShift_q;
    logic [7:0] txShift_q;
    logic [7:0] regPtr_q;
    logic [7:0] ctrl_q;
    logic byteIdx_q;
    logic readDir_q;
    logic masterNack_q;
    logic sdaOe_q;
    logic sclOe_q;
    logic lineLow_q;
    logic busy_q;
    logic startPulse_q;
    logic startPress_q;
    logic startFast_q;
    logic clearNow;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic [7:0] rxByte;
    logic [7:0] nextTx;

    // Source word for a register pointer; unmapped pointers read zero
    function automatic logic [15:0] selWord(input logic [7:0] ptr, input logic [15:0] res);
        logic [15:0] w;
        w = 16'h0000;
        case ({ptr[7:1], 1'b0})
            REG_RESULT: w = res;
            REG_CAL_ONE: w = CAL_ROM[0];
            REG_CAL_TWO: w = CAL_ROM[1];
            REG_CAL_THREE: w = CAL_ROM[2];
            REG_CAL_FOUR: w = CAL_ROM[3];
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : selWord

    // Even pointer gives the high byte, odd the low byte
    function automatic logic [7:0] selByte(input logic [7:0] ptr, input logic [15:0] res);
        logic [15:0] w;
        w = selWord(ptr, res);
        return ptr[0] ? w[7:0] : w[15:8];
    endfunction : selByte

    // Pins cross into sys_clk through two flops; third stage only for edges
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sclSync_q <= 3'b111;
            sdaSync_q <= 3'b111;
            mclkSync_q <= 3'b000;
            clrSync_q <= 2'b00;
        end
        else
        begin
            sclSync_q <= {sclSync_q[1:0], sclIn};
            sdaSync_q <= {sdaSync_q[1:0], sdaIn};
            mclkSync_q <= {mclkSync_q[1:0], mclkIn};
            clrSync_q <= {clrSync_q[0], master_clear_n};
        end
    end

    assign clearNow = !clrSync_q[1];
    assign sclRise = sclSync_q[1] && !sclSync_q[2];
    assign sclFall = !sclSync_q[1] && sclSync_q[2];
    assign startCond = sclSync_q[1] && sclSync_q[2] && !sdaSync_q[1] && sdaSync_q[2];
    assign stopCond = sclSync_q[1] && sclSync_q[2] && sdaSync_q[1] && !sdaSync_q[2];
    assign rxByte = rxShift_q;
    assign nextTx = selByte(regPtr_q, cv.result);

    // Data bits sampled only while the clock rises
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rxShift_q <= 8'h00;
            masterNack_q <= 1'b0;
        end
        else if (clearNow)
        begin
            rxShift_q <= 8'h00;
            masterNack_q <= 1'b0;
        end
        else if (sclRise && bitCnt_q != BIT_ACK)
            rxShift_q <= {rxShift_q[6:0], sdaSync_q[1]};
        else if (sclRise && state_q == ST_READ)
            masterNack_q <= sdaSync_q[1];
    end

    // Protocol sequencer; all line changes happen after a falling clock
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            byteIdx_q <= 1'b0;
            readDir_q <= 1'b0;
            lineLow_q <= 1'b0;
            txShift_q <= 8'h00;
            regPtr_q <= PTR_RESET;
            ctrl_q <= CTRL_RESET;
            startPulse_q <= 1'b0;
            startPress_q <= 1'b0;
            startFast_q <= 1'b0;
        end
        else if (clearNow)
        begin
            state_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            byteIdx_q <= 1'b0;
            readDir_q <= 1'b0;
            lineLow_q <= 1'b0;
            txShift_q <= 8'h00;
            regPtr_q <= PTR_RESET;
            ctrl_q <= CTRL_RESET;
            startPulse_q <= 1'b0;
            startPress_q <= 1'b0;
            startFast_q <= 1'b0;
        end
        else
        begin
            startPulse_q <= 1'b0;
            if (startCond)
            begin
                // Repeated start reopens the address phase, pointer kept
                state_q <= ST_ADDR;
                // Clock fall closing the start wraps count to bit zero
                bitCnt_q <= 4'hf;
                byteIdx_q <= 1'b0;
                lineLow_q <= 1'b0;
            end
            else if (stopCond)
            begin
                state_q <= ST_IDLE;
                bitCnt_q <= 4'h0;
                lineLow_q <= 1'b0;
            end
            else if (sclFall)
            begin
                case (state_q)
                    ST_ADDR:
                    begin
                        if (bitCnt_q == BIT_LAST)
                        begin
                            if (rxByte[7:1] == DEV_ADDR)
                            begin
                                readDir_q <= rxByte[0];
                                lineLow_q <= 1'b1;
                                bitCnt_q <= BIT_ACK;
                            end
                            else
                            begin
                                state_q <= ST_IDLE;
                                lineLow_q <= 1'b0;
                                bitCnt_q <= 4'h0;
                            end
                        end
                        else if (bitCnt_q == BIT_ACK)
                        begin
                            bitCnt_q <= 4'h0;
                            if (readDir_q)
                            begin
                                state_q <= ST_READ;
                                txShift_q <= {nextTx[6:0], 1'b0};
                                lineLow_q <= !nextTx[7];
                            end
                            else
                            begin
                                state_q <= ST_WRITE;
                                lineLow_q <= 1'b0;
                            end
                        end
                        else
                            bitCnt_q <= bitCnt_q + 4'h1;
                    end
                    ST_WRITE:
                    begin
                        if (bitCnt_q == BIT_LAST)
                        begin
                            lineLow_q <= 1'b1;
                            bitCnt_q <= BIT_ACK;
                            if (!byteIdx_q)
                                regPtr_q <= rxByte;
                            else if (regPtr_q == REG_CTRL)
                            begin
                                ctrl_q <= rxByte;
                                if (rxByte == CTRL_TEMP_SLOW || rxByte == CTRL_TEMP_FAST
                                    || rxByte == CTRL_PRES_SLOW || rxByte == CTRL_PRES_FAST)
                                begin
                                    startPulse_q <= 1'b1;
                                    startPress_q <= (rxByte == CTRL_PRES_SLOW)
                                        || (rxByte == CTRL_PRES_FAST);
                                    startFast_q <= rxByte[CTRL_PRESCALE_BIT];
                                end
                            end
                            byteIdx_q <= 1'b1;
                        end
                        else if (bitCnt_q == BIT_ACK)
                        begin
                            lineLow_q <= 1'b0;
                            bitCnt_q <= 4'h0;
                        end
                        else
                            bitCnt_q <= bitCnt_q + 4'h1;
                    end
                    ST_READ:
                    begin
                        if (bitCnt_q == BIT_LAST)
                        begin
                            // Release for the host's acknowledge slot
                            lineLow_q <= 1'b0;
                            bitCnt_q <= BIT_ACK;
                            regPtr_q <= regPtr_q + 8'h01;
                        end
                        else if (bitCnt_q == BIT_ACK)
                        begin
                            bitCnt_q <= 4'h0;
                            if (masterNack_q)
                            begin
                                state_q <= ST_IDLE;
                                lineLow_q <= 1'b0;
                            end
                            else
                            begin
                                txShift_q <= {nextTx[6:0], 1'b0};
                                lineLow_q <= !nextTx[7];
                            end
                        end
                        else
                        begin
                            bitCnt_q <= bitCnt_q + 4'h1;
                            txShift_q <= {txShift_q[6:0], 1'b0};
                            lineLow_q <= !txShift_q[7];
                        end
                    end
                    default:
                    begin
                        lineLow_q <= 1'b0;
                        bitCnt_q <= 4'h0;
                    end
                endcase
            end
        end
    end

    // Open drain only: low enable pulls low, level never driven high
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sdaOe_q <= 1'b1;
            sclOe_q <= 1'b1;
        end
        else
        begin
            sdaOe_q <= !lineLow_q;
            sclOe_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            busy_q <= 1'b0;
        else
            busy_q <= cv.busy;
    end

    assign cv.clear = clearNow;
    assign cv.start = startPulse_q;
    assign cv.pressure = startPress_q;
    assign cv.fastDiv = startFast_q;
    assign cv.mclkTick = mclkSync_q[1] && !mclkSync_q[2];

    psi_conv #(
        .CONV_LEN(CONV_LEN)
    ) u_conv (
        .sys_clk(sys_clk),
        .rst(rst),
        .cv(cv),
        .tempSample(tempSample),
        .pressSample(pressSample)
    );

    // Output data level is constant low; the enables carry the signal
    assign sdaOut = 1'b0;
    assign sclOut = 1'b0;
    assign sdaOe = sdaOe_q;
    assign sclOe = sclOe_q;
    assign convBusy = busy_q;
endmodule : psi_top

// File: verification/psi_i2c_master.sv
// Behavioural serial bus master for the sensor's clock and data lines.
`timescale 1ns/1ps
module psi_i2c_master
(
    input wire logic sys_clk,
    input wire logic sclLine,
    input wire logic sdaLine,
    output logic sclLow,
    output logic sdaLow
);
    initial
    begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end
    // Each level outlasts the slave's synchroniser and edge detector
    task automatic quarter();
        repeat (8) @(posedge sys_clk);
        #1;
    endtask : quarter
    task automatic bus_start();
        quarter();
        sdaLow = 1'b0;
        quarter();
        sclLow = 1'b0;
        quarter();
        sdaLow = 1'b1;
        quarter();
        sclLow = 1'b1;
        quarter();
    endtask : bus_start
    task automatic bus_stop();
        sdaLow = 1'b1;
        quarter();
        sclLow = 1'b0;
        quarter();
        sdaLow = 1'b0;
        quarter();
    endtask : bus_stop
    task automatic clock_bit(input logic b, output logic s);
        sdaLow = !b;
        quarter();
        sclLow = 1'b0;
        quarter();
        s = sdaLine;
        quarter();
        sclLow = 1'b1;
        quarter();
    endtask : clock_bit
    task automatic send_byte(input logic [7:0] b, output logic ackd);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(b[i], s);
        clock_bit(1'b1, s);
        ackd = !s;
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(1'b1, s);
            b[i] = s;
        end
        clock_bit(nack, s);
    endtask : recv_byte
endmodule : psi_i2c_master

// File: verification/psi_top_assertions.sv
// Port-level assertion checker for the pressure sensor serial slave.
`timescale 1ns/1ps
module psi_top_checker
#(
    parameter int CONV_LEN = 4
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic master_clear_n,
    input wire logic mclkIn,
    input wire logic sclIn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic convBusy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic mclkQ;
    logic ackClockedQ;
    logic [7:0] clearHistQ;
    int mclkRisesQ;
    always_ff @(posedge sys_clk)
        mclkQ <= mclkIn;
    always_ff @(posedge sys_clk)
        clearHistQ <= {clearHistQ[6:0], !master_clear_n};
    // Counts raw edges; the device sees them later, so the tally can miss one edge that arrives just before convBusy rises
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            mclkRisesQ <= 0;
        else if (!convBusy)
            mclkRisesQ <= 0;
        else if (mclkIn && !mclkQ)
            mclkRisesQ <= mclkRisesQ + 1;
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            ackClockedQ <= 1'b0;
        else
            ackClockedQ <= !sdaOe && (ackClockedQ || sclIn);
    end
    sequence busyHeld;
        convBusy [*4];
    endsequence
    sequence clearHeld;
        !master_clear_n [*5];
    endsequence
    AST_SCL_NEVER_DRIVEN: assert property (sclOe && !sclOut)
        else $error("device pulls the serial clock");
    AST_SDA_NEVER_HIGH: assert property (!sdaOut)
        else $error("device drives data high");
    AST_CLEAR_IDLES: assert property (clearHeld |-> !convBusy && sdaOe)
        else $error("master clear leaves device active");
    AST_SDA_MOVES_SCL_LOW: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("device changes data while clock high");
    AST_ACK_SPANS_CLOCK: assert property ($rose(sdaOe) |-> $past(ackClockedQ))
        else $error("data released before a clock high phase");
    AST_BUSY_FROM_ACK: assert property ($rose(convBusy) |-> !sdaOe && !sclIn)
        else $error("conversion started outside an acknowledge");
    AST_BUSY_HOLDS: assert property ($rose(convBusy) |-> busyHeld)
        else $error("conversion too short");
    AST_BUSY_NEEDS_MCLK: assert property
        ($fell(convBusy) && clearHistQ == 8'h00 |-> mclkRisesQ >= 2 * CONV_LEN - 1)
        else $error("conversion ended without enough master clocks");
endmodule : psi_top_checker

// File: verification/tb_psi_top.sv
// Self-checking bench for the pressure sensor serial slave.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            $display("unexpected %s: expected %h, seen %h", nm, exp, got); \
            error_cnt++; \
        end \
    end
module tb_psi_top;
    import psi_pkg::*;
    localparam int CONV_LEN = 4;
    localparam logic [63:0] CAL_ALL = 64'he09f_7eb4_f0b8_8847;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic masterClearN = 1'b0;
    logic mclkIn = 1'b0;
    logic mclkRun = 1'b1;
    logic mclkQ = 1'b0;
    logic [15:0] tempSample = 16'h0000;
    logic [15:0] pressSample = 16'h0000;
    logic sclOut, sclOe, sdaOut, sdaOe, convBusy, sclLow, sdaLow;
    wire sclLine = (sclOe | sclOut) & !sclLow;
    wire sdaLine = (sdaOe | sdaOut) & !sdaLow;
    int error_cnt = 0;
    int check_count = 0;
    int rises = 0;
    psi_top #(.CAL_WORD_ONE(CAL_ALL[63:48]), .CAL_WORD_TWO(CAL_ALL[47:32]),
        .CAL_WORD_THREE(CAL_ALL[31:16]), .CAL_WORD_FOUR(CAL_ALL[15:0]),
        .CONV_LEN(CONV_LEN)) i_psi_top (.sys_clk, .rst, .master_clear_n(masterClearN),
        .mclkIn, .sclIn(sclLine), .sclOut, .sclOe, .sdaIn(sdaLine), .sdaOut, .sdaOe,
        .tempSample, .pressSample, .convBusy);
    psi_i2c_master i_psi_i2c_master (.sys_clk, .sclLine, .sdaLine, .sclLow, .sdaLow);
    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end
    always
    begin
        repeat (10) @(posedge sys_clk);
        #1;
        if (mclkRun)
            mclkIn = ~mclkIn;
    end
    always @(posedge sys_clk)
    begin
        mclkQ <= mclkIn;
        if (convBusy && mclkIn && !mclkQ)
            rises <= rises + 1;
    end
    function automatic int exp_div(input logic [7:0] code);
        return code[CTRL_PRESCALE_BIT] ? 64 : 2;
    endfunction : exp_div
    function automatic logic [15:0] exp_result(input logic [7:0] code, input logic [15:0] t,
        input logic [15:0] p);
        return (code == CTRL_PRES_SLOW || code == CTRL_PRES_FAST) ? p : t;
    endfunction : exp_result
    task automatic summarize();
        $display("checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic put(input logic [7:0] b, input logic expAck);
        logic a;
        i_psi_i2c_master.send_byte(b, a);
        `CHECK("acknowledge", expAck, a)
    endtask : put
    task automatic read_word(input logic [7:0] ptr, output logic [15:0] w);
        i_psi_i2c_master.bus_start();
        put({DEV_ADDR, 1'b0}, 1'b1);
        put(ptr, 1'b1);
        i_psi_i2c_master.bus_start();
        put({DEV_ADDR, 1'b1}, 1'b1);
        i_psi_i2c_master.recv_byte(w[15:8], 1'b0);
        i_psi_i2c_master.recv_byte(w[7:0], 1'b1);
        i_psi_i2c_master.bus_stop();
    endtask : read_word
    task automatic write_ctrl(input logic [7:0] code);
        i_psi_i2c_master.bus_start();
        put({DEV_ADDR, 1'b0}, 1'b1);
        put(REG_CTRL, 1'b1);
        put(code, 1'b1);
        i_psi_i2c_master.bus_stop();
    endtask : write_ctrl
    task automatic convert(input logic [7:0] code);
        logic [15:0] w;
        int n;
        tempSample = 16'($urandom);
        pressSample = 16'($urandom);
        rises = 0;
        n = 0;
        write_ctrl(code);
        `CHECK("busy after command", 1'b1, convBusy)
        mclkRun = 1'b0;
        repeat (300) @(posedge sys_clk);
        `CHECK("busy with clock stopped", 1'b1, convBusy)
        #1 mclkRun = 1'b1;
        while (convBusy === 1'b1 && n < 8000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHECK("conversion finished", 1'b0, convBusy)
        `CHECK("prescale", 1'b1, rises >= exp_div(code) * CONV_LEN - 1 &&
            rises <= exp_div(code) * CONV_LEN + 1)
        read_word(REG_RESULT, w);
        `CHECK("result", exp_result(code, tempSample, pressSample), w)
    endtask : convert
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
    initial
    begin
        logic [15:0] w [4];
        logic [6:0] a;
        void'($urandom(65630));
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 masterClearN = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        for (int i = 0; i < 4; i++)
        begin
            read_word(REG_CAL_ONE + 8'(2 * i), w[i]);
            `CHECK("calibration word", CAL_ALL[63 - 16 * i -: 16], w[i])
        end
        `CHECK("coeff_one", 14'd8351, w[0][13:0])
        `CHECK("coeff_two", 9'd255, {w[1][15:9], w[0][15:14]})
        `CHECK("coeff_three", 9'd180, w[1][8:0])
        `CHECK("coeff_four", 13'd4280, w[2][12:0])
        `CHECK("coeff_five", 7'd71, {w[3][15:12], w[2][15:13]})
        `CHECK("coeff_six", 12'd2119, w[3][11:0])
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 0) ? 7'h76 : 7'($urandom);
            if (a == DEV_ADDR)
                a = 7'h37;
            i_psi_i2c_master.bus_start();
            put({a, 1'(i)}, 1'b0);
            i_psi_i2c_master.bus_stop();
        end
        convert(CTRL_TEMP_SLOW);
        convert(CTRL_TEMP_FAST);
        convert(CTRL_PRES_SLOW);
        convert(CTRL_PRES_FAST);
        write_ctrl(8'h55);
        repeat (8) @(posedge sys_clk);
        `CHECK("busy after unknown code", 1'b0, convBusy)
        #1;
        write_ctrl(CTRL_PRES_FAST);
        masterClearN = 1'b0;
        repeat (6) @(posedge sys_clk);
        `CHECK("busy under clear", 1'b0, convBusy)
        #1 masterClearN = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        read_word(REG_RESULT, w[0]);
        `CHECK("result after clear", RESULT_RESET, w[0])
        summarize();
    end
endmodule : tb_psi_top
bind psi_top psi_top_checker #(.CONV_LEN(CONV_LEN)) i_psi_top_checker (.sys_clk, .rst,
    .master_clear_n, .mclkIn, .sclIn, .sclOut, .sclOe, .sdaOut, .sdaOe, .convBusy);
